// *** bit_exec_defs.vh ***
// Constants for the bit-level sequence instruction execution block.
`ifndef BIT_EXEC_DEFS_VH
`define BIT_EXEC_DEFS_VH
// ==========================================
// Operation codes
`define OP_NOP 4'h0
`define OP_TSTN_LD 4'h1
`define OP_TSTN_AND 4'h2
`define OP_TSTN_OR 4'h3
`define OP_WRITE 4'h4
`define OP_WRITE_INV 4'h5
`define OP_LATCH_SET 4'h6
`define OP_LATCH_EXEC 4'h7
// ==========================================
// Operand areas
`define AREA_CORE_IO 3'h0
`define AREA_WORK 3'h1
`define AREA_HOLD 3'h2
`define AREA_AUX 3'h3
`define AREA_DATA_WORD 3'h4
`define AREA_EXT_BANK 3'h5
`define AREA_OTHER 3'h6
// ==========================================
// Word ranges of writable areas
`define CORE_IO_LAST_WORD 16'h17FF
`define WORK_LAST_WORD 16'h01FF
`define HOLD_LAST_WORD 16'h01FF
`define AUX_FIRST_WORD 16'h01C0
`define AUX_LAST_WORD 16'h03BF
// ==========================================
// Bit number field of a word-supplied bit index
`define BIT_NUM_MASK 16'h000F
`define FLAG_RESET 1'b0
// ==========================================
// Timing
// Edges after reset release before the synchronised retain levels are valid.
`define RETAIN_SETTLE 2'h2
`endif

// *** bit_store.v ***
// Bit memory with separate write and read ports, registered read data and contents kept through reset.
`timescale 1ns/10ps
`default_nettype none
module bit_store #(
	parameter AW = 13,
	parameter RETAIN = 0
) (
	input wire mclk,
	input wire rst_n,
	input wire wr_en,
	input wire [AW-1:0] waddr,
	input wire [15:0] wmask,
	input wire [15:0] wdata,
	input wire [AW-1:0] raddr,
	output reg [15:0] rdata_q
);
	reg [15:0] mem [0:(1<<AW)-1];
	// ==========================================
	// Storage
	// Memory contents are never cleared by reset, so retained areas survive restart.
	always @(posedge mclk) begin
		if (wr_en) begin
			mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
		end
	end
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= mem[raddr];
		end
	end
endmodule
`default_nettype wire

// *** bit_exec.v ***
// Execution unit for inverted bit test, bit write and latching relay instructions.
// ==========================================
// How it works
// - Inverted test yields complement of selected bit.
// - Inverted test accepts data word, bank areas.
// - Early variant clears flags; fast variant keeps.
// - AND form ANDs bit with prior condition.
// - OR form ORs bit with prior condition.
// - Plain write stores condition into memory bit.
// - Immediate write also drives output terminal now.
// - No terminal update for remote, group-2 units.
// - Inverted write stores complement, maybe terminal.
// - Write and latch operands limited to ranges.
// - Duplex variant runs no immediate forms.
// - Bit writes leave all flags untouched.
// - Set turns latch on and holds.
// - Reset turns latch off.
// - Reset wins over simultaneous set.
// - Set ignored while reset active.
// - Immediate latch refreshes terminal, with exceptions.
// - Latch holds state while interlocked.
// - Holding area bits survive power loss.
// - Core IO retained only with both retain bits.
// - Bit number uses lowest hex digit only.
`timescale 1ns/10ps
`default_nettype none
`include "bit_exec_defs.vh"
module bit_exec #(
	parameter AW = 13,
	parameter EARLY_VARIANT = 0,
	parameter DUPLEX_VARIANT = 0
) (
	input wire mclk,
	input wire rst_n,
	input wire instr_valid,
	output wire instr_ready,
	input wire [3:0] instr_op,
	input wire instr_immediate,
	input wire [2:0] instr_area,
	input wire [15:0] instr_word,
	input wire [15:0] instr_bit,
	input wire instr_local_unit,
	input wire interlock,
	input wire io_retain_control,
	input wire setup_hold_option,
	input wire scan_start,
	output reg exec_cond_q,
	output reg fault_flag_q,
	output reg equal_flag_q,
	output reg sign_flag_q,
	output reg operand_error_q,
	output reg done_q,
	output reg term_valid_q,
	output reg [15:0] term_word_q,
	output reg [3:0] term_bit_q,
	output reg term_value_q,
	output reg io_retain_active_q
);
	localparam ST_IDLE = 3'b001;
	localparam ST_READ = 3'b010;
	localparam ST_EXEC = 3'b100;
	reg [2:0] state_q;
	reg [3:0] op_q;
	reg imm_q;
	reg local_q;
	reg [2:0] area_q;
	reg [15:0] word_q;
	reg [3:0] bit_q;
	reg set_in_q;
	reg mem_wr;
	reg [15:0] mem_wdata;
	reg cond_d;
	reg bit_value;
	reg write_ok;
	reg result_bit;
	wire [15:0] rdata;
	wire [15:0] bit_mask;
	wire [15:0] sel_bits;
	wire is_test;
	wire is_write;
	wire imm_allowed;
	reg rst_sync1_q;
	reg rst_sync2_q;
	reg hold_sync1_q;
	reg hold_sync2_q;
	reg ilk_sync1_q;
	reg ilk_sync2_q;
	assign instr_ready = (state_q == ST_IDLE);
	assign bit_mask = 16'h0001 << bit_q;
	assign sel_bits = instr_bit & `BIT_NUM_MASK;
	assign is_test = (op_q == `OP_TSTN_LD) || (op_q == `OP_TSTN_AND) || (op_q == `OP_TSTN_OR);
	assign is_write = (op_q == `OP_WRITE) || (op_q == `OP_WRITE_INV) || (op_q == `OP_LATCH_EXEC);
	assign imm_allowed = (DUPLEX_VARIANT == 0);
	// ==========================================
	// Input synchronisers
	// Retain and interlock levels come from outside this clock and are resynchronised.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync1_q <= 1'b0;
			rst_sync2_q <= 1'b0;
			hold_sync1_q <= 1'b0;
			hold_sync2_q <= 1'b0;
			ilk_sync1_q <= 1'b0;
			ilk_sync2_q <= 1'b0;
		end else begin
			rst_sync1_q <= io_retain_control;
			rst_sync2_q <= rst_sync1_q;
			hold_sync1_q <= setup_hold_option;
			hold_sync2_q <= hold_sync1_q;
			ilk_sync1_q <= interlock;
			ilk_sync2_q <= ilk_sync1_q;
		end
	end
	// ==========================================
	// Retain setting capture
	// Sampled once the synchronisers have filled; a later change needs a restart.
	reg captured_q;
	reg [1:0] settle_q;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			captured_q <= 1'b0;
			settle_q <= 2'h0;
			io_retain_active_q <= 1'b0;
		end else if (!captured_q) begin
			if (settle_q == `RETAIN_SETTLE) begin
				captured_q <= 1'b1;
				io_retain_active_q <= rst_sync2_q & hold_sync2_q;
			end else begin
				settle_q <= settle_q + 2'h1;
			end
		end
	end
	// ==========================================
	// Memory
	// Holding words sit in the upper half of the store and are never scrubbed, so they
	// survive a restart; the lower half is cleared after restart unless retention is on.
	wire hold_area = (area_q == `AREA_HOLD);
	wire [AW-1:0] store_addr = {hold_area, word_q[AW-2:0]};
	wire [AW-1:0] scrub_last = {1'b0, {(AW-1){1'b1}}};
	reg [AW-1:0] scrub_q;
	reg scrub_busy_q;
	wire scrub_wr = scrub_busy_q && captured_q && !io_retain_active_q;
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			scrub_q <= {AW{1'b0}};
			scrub_busy_q <= 1'b1;
		end else if (scrub_busy_q && captured_q) begin
			if (io_retain_active_q || (scrub_q == scrub_last)) begin
				scrub_busy_q <= 1'b0;
			end
			scrub_q <= scrub_q + {{(AW-1){1'b0}}, 1'b1};
		end
	end
	bit_store #(.AW(AW), .RETAIN(1)) u_store (
		.mclk(mclk),
		.rst_n(rst_n),
		.wr_en(mem_wr | scrub_wr),
		.waddr(scrub_wr ? scrub_q : store_addr),
		.wmask(scrub_wr ? 16'hFFFF : bit_mask),
		.wdata(scrub_wr ? 16'h0000 : mem_wdata),
		.raddr(store_addr),
		.rdata_q(rdata)
	);
	// ==========================================
	// Operand range check
	// Tests may read any area; only writes and latches are range checked.
	always @* begin
		case (area_q)
			`AREA_CORE_IO: write_ok = (word_q <= `CORE_IO_LAST_WORD);
			`AREA_WORK: write_ok = (word_q <= `WORK_LAST_WORD);
			`AREA_HOLD: write_ok = (word_q <= `HOLD_LAST_WORD);
			`AREA_AUX: write_ok = (word_q >= `AUX_FIRST_WORD) && (word_q <= `AUX_LAST_WORD);
			default: write_ok = 1'b0;
		endcase
	end
	// ==========================================
	// Evaluation
	always @* begin
		bit_value = |(rdata & bit_mask);
		cond_d = exec_cond_q;
		result_bit = bit_value;
		mem_wr = 1'b0;
		mem_wdata = 16'h0000;
		case (op_q)
			`OP_TSTN_LD: cond_d = !bit_value;
			`OP_TSTN_AND: cond_d = exec_cond_q & !bit_value;
			`OP_TSTN_OR: cond_d = exec_cond_q | !bit_value;
			`OP_WRITE: result_bit = exec_cond_q;
			`OP_WRITE_INV: result_bit = !exec_cond_q;
			// The condition reaching the latch is its reset input; reset beats set.
			`OP_LATCH_EXEC: begin
				if (exec_cond_q) begin
					result_bit = 1'b0;
				end else if (set_in_q) begin
					result_bit = 1'b1;
				end else begin
					result_bit = bit_value;
				end
			end
			default: cond_d = exec_cond_q;
		endcase
		// Store only in the execute state, so a later condition change cannot rewrite the bit.
		if ((state_q == ST_EXEC) && is_write && write_ok && !ilk_sync2_q) begin
			mem_wr = 1'b1;
			mem_wdata = {16{result_bit}};
		end
	end
	// ==========================================
	// Sequencer
	// One instruction at a time; the condition register chains between them.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			op_q <= `OP_NOP;
			imm_q <= 1'b0;
			local_q <= 1'b0;
			area_q <= `AREA_OTHER;
			word_q <= 16'h0000;
			bit_q <= 4'h0;
			exec_cond_q <= 1'b0;
			operand_error_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (scan_start) begin
						exec_cond_q <= 1'b1;
					end
					if (instr_valid && !scrub_busy_q) begin
						op_q <= instr_op;
						imm_q <= instr_immediate;
						local_q <= instr_local_unit;
						area_q <= instr_area;
						word_q <= instr_word;
						bit_q <= sel_bits[3:0];
						state_q <= ST_READ;
					end
				end
				ST_READ: begin
					state_q <= ST_EXEC;
				end
				ST_EXEC: begin
					state_q <= ST_IDLE;
					done_q <= 1'b1;
					exec_cond_q <= cond_d;
					operand_error_q <= is_write && !write_ok;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	// ==========================================
	// Condition flags
	// Only the early variant clears the flags, and only on a test; writes never touch them.
	wire flag_clear = (state_q == ST_EXEC) && is_test && (EARLY_VARIANT != 0);
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fault_flag_q <= `FLAG_RESET;
			equal_flag_q <= `FLAG_RESET;
			sign_flag_q <= `FLAG_RESET;
		end else if (flag_clear) begin
			fault_flag_q <= 1'b0;
			equal_flag_q <= 1'b0;
			sign_flag_q <= 1'b0;
		end
	end
	// ==========================================
	// Latch set input
	// The set condition is captured by its own instruction, ahead of the reset rung.
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			set_in_q <= 1'b0;
		end else if ((state_q == ST_EXEC) && (op_q == `OP_LATCH_SET)) begin
			set_in_q <= exec_cond_q;
		end
	end
	// ==========================================
	// Immediate terminal refresh
	// Only local output units in the core IO area are refreshed; others change in memory.
	wire term_fire = mem_wr && imm_q && imm_allowed && local_q
		&& (area_q == `AREA_CORE_IO);
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			term_valid_q <= 1'b0;
			term_word_q <= 16'h0000;
			term_bit_q <= 4'h0;
			term_value_q <= 1'b0;
		end else begin
			term_valid_q <= term_fire;
			if (term_fire) begin
				term_word_q <= word_q;
				term_bit_q <= bit_q;
				term_value_q <= result_bit;
			end
		end
	end
endmodule
`default_nettype wire

// *** bit_exec_chk.sv ***
// Port checker for the bit execution block.
`timescale 1ns/10ps
`default_nettype none
module bit_exec_chk (
	input wire mclk,
	input wire rst_n,
	input wire [3:0] instr_op,
	input wire instr_immediate,
	input wire [2:0] instr_area,
	input wire [15:0] instr_word,
	input wire [15:0] instr_bit,
	input wire instr_local_unit,
	input wire exec_cond_q,
	input wire fault_flag_q,
	input wire operand_error_q,
	input wire done_q,
	input wire term_valid_q,
	input wire [15:0] term_word_q,
	input wire [3:0] term_bit_q,
	input wire term_value_q
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	done_once_a: assert property (done_q |=> !done_q)
		else $error("done held too long");
	term_cause_a: assert property (term_valid_q |-> done_q && $past(instr_immediate, 3)
		&& $past(instr_local_unit, 3)) else $error("refresh without cause");
	term_addr_a: assert property (term_valid_q |-> term_word_q == $past(instr_word, 3)
		&& term_bit_q == $past(instr_bit[3:0], 3)) else $error("refresh address wrong");
	wr_value_a: assert property (term_valid_q && $past(instr_op, 3) == 4'h4
		|-> term_value_q == $past(exec_cond_q, 3)) else $error("write value wrong");
	inv_value_a: assert property (term_valid_q && $past(instr_op, 3) == 4'h5
		|-> term_value_q != $past(exec_cond_q, 3)) else $error("inverted value wrong");
	wr_flags_a: assert property (done_q && $past(instr_op, 3) inside {4'h4, 4'h5}
		|-> $stable(fault_flag_q)) else $error("write touched flag");
	test_flags_a: assert property (done_q && $past(instr_op, 3) == 4'h1
		|-> $stable(fault_flag_q)) else $error("test touched flag");
	bad_area_a: assert property (done_q && $past(instr_op, 3) == 4'h4
		&& $past(instr_area, 3) >= 3'h4 |-> operand_error_q) else $error("bad area taken");
	good_area_a: assert property (done_q && $past(instr_op, 3) == 4'h4
		&& $past(instr_area, 3) == 3'h0 |-> !operand_error_q) else $error("good area refused");
	latch_reset_a: assert property (term_valid_q && $past(instr_op, 3) == 4'h7
		&& $past(exec_cond_q, 3) |-> !term_value_q) else $error("latch reset lost");
	cover property (term_valid_q && term_value_q);
	cover property (done_q && operand_error_q);
	cover property (done_q && $past(instr_op, 3) == 4'h7);
endmodule
bind bit_exec bit_exec_chk u_chk (.mclk(mclk), .rst_n(rst_n), .instr_op(instr_op),
	.instr_immediate(instr_immediate), .instr_area(instr_area), .instr_word(instr_word),
	.instr_bit(instr_bit), .instr_local_unit(instr_local_unit), .exec_cond_q(exec_cond_q),
	.fault_flag_q(fault_flag_q), .operand_error_q(operand_error_q), .done_q(done_q),
	.term_valid_q(term_valid_q), .term_word_q(term_word_q), .term_bit_q(term_bit_q),
	.term_value_q(term_value_q));
`default_nettype wire

// *** out_term.sv ***
// Output terminal model that records immediate refreshes.
`timescale 1ns/10ps
`default_nettype none
module out_term (
	input wire mclk,
	input wire term_valid_q,
	input wire term_value_q,
	output var logic pin,
	output var int hits
);
	initial begin
		pin = 1'b0;
		hits = 0;
	end
	always @(posedge mclk) begin
		if (term_valid_q) begin
			hits <= hits + 1;
			pin <= term_value_q;
		end
	end
endmodule
`default_nettype wire

// *** tb_bit_exec.sv ***
// Self-checking testbench for the bit execution block.
`timescale 1ns/10ps
`default_nettype none
`include "bit_exec_defs.vh"
module tb_bit_exec;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic v = 1'b0, imm = 1'b0, loc = 1'b1, ilk = 1'b0, scan = 1'b0;
	logic retain = 1'b0, hold_opt = 1'b0;
	logic [3:0] op = 4'h0;
	logic [2:0] area = 3'h0;
	logic [15:0] word = 16'h0000, bitn = 16'h0000;
	wire rdy, cond, flt, eq, sgn, oerr, done, tv, tval, pin, act;
	wire [15:0] tw;
	wire [3:0] tb4;
	int hits;
	int mismatches = 0;
	int samples_checked = 0;
	bit_exec #(.AW(4)) dut (.mclk(mclk), .rst_n(rst_n), .instr_valid(v), .instr_ready(rdy),
		.instr_op(op), .instr_immediate(imm), .instr_area(area), .instr_word(word),
		.instr_bit(bitn), .instr_local_unit(loc), .interlock(ilk), .io_retain_control(retain),
		.setup_hold_option(hold_opt), .scan_start(scan), .exec_cond_q(cond), .fault_flag_q(flt),
		.equal_flag_q(eq), .sign_flag_q(sgn), .operand_error_q(oerr), .done_q(done),
		.term_valid_q(tv), .term_word_q(tw), .term_bit_q(tb4), .term_value_q(tval),
		.io_retain_active_q(act));
	out_term u_term (.mclk(mclk), .term_valid_q(tv), .term_value_q(tval), .pin(pin),
		.hits(hits));
	initial begin
		forever #2.5 mclk = ~mclk;
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic issue(input logic [3:0] o, input logic [2:0] a, input logic [15:0] w,
		input logic [15:0] b, input logic i);
		int n;
		@(posedge mclk);
		v <= 1'b1;
		op <= o;
		area <= a;
		word <= w;
		bitn <= b;
		imm <= i;
		@(posedge mclk);
		v <= 1'b0;
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (!done && n < 8);
		chk("done", done, 1'b1);
		chk("ready", rdy, 1'b1);
		@(posedge mclk);
		#1;
	endtask
	task automatic cond_set(input logic on);
		@(posedge mclk);
		scan <= 1'b1;
		@(posedge mclk);
		scan <= 1'b0;
		if (!on) issue(`OP_TSTN_LD, `AREA_CORE_IO, 16'h0005, 16'h0003, 1'b0);
	endtask
	task automatic latch(input logic s, input logic r, input logic exp);
		cond_set(s);
		issue(`OP_LATCH_SET, `AREA_CORE_IO, 16'h0006, 16'h0000, 1'b0);
		cond_set(r);
		issue(`OP_LATCH_EXEC, `AREA_CORE_IO, 16'h0006, 16'h0000, 1'b1);
		chk("latch pin", pin, exp);
		issue(`OP_TSTN_LD, `AREA_CORE_IO, 16'h0006, 16'h0000, 1'b0);
		chk("latch", cond, !exp);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_write();
		cond_set(1'b1);
		issue(`OP_WRITE, `AREA_CORE_IO, 16'h0005, 16'h0003, 1'b1);
		chk("pin", pin, 1'b1);
		issue(`OP_WRITE_INV, `AREA_CORE_IO, 16'h0005, 16'h0004, 1'b1);
		chk("pin inv", pin, 1'b0);
		chk("flags", {flt, eq, sgn}, 3'h0);
		issue(`OP_TSTN_LD, `AREA_CORE_IO, 16'h0005, 16'h0003, 1'b0);
		chk("mem bit", cond, 1'b0);
		issue(`OP_TSTN_LD, `AREA_CORE_IO, 16'h0005, 16'h0004, 1'b0);
		chk("mem bit inv", cond, 1'b1);
		$display("write test done");
	endtask
	task automatic t_test();
		cond_set(1'b1);
		issue(`OP_TSTN_LD, `AREA_DATA_WORD, 16'h0005, 16'h0013, 1'b0);
		chk("tstn ld", cond, 1'b0);
		issue(`OP_TSTN_OR, `AREA_EXT_BANK, 16'h0005, 16'h0004, 1'b0);
		chk("tstn or", cond, 1'b1);
		issue(`OP_TSTN_AND, `AREA_DATA_WORD, 16'h0005, 16'h0003, 1'b0);
		chk("tstn and", cond, 1'b0);
		chk("flags", flt, 1'b0);
		issue(`OP_WRITE, `AREA_WORK, 16'h0003, 16'h0000, 1'b0);
		chk("rung end", oerr, 1'b0);
		$display("test test done");
	endtask
	task automatic t_remote();
		int n;
		n = hits;
		issue(`OP_WRITE, `AREA_CORE_IO, 16'h0007, 16'h0001, 1'b0);
		@(posedge mclk);
		loc <= 1'b0;
		issue(`OP_WRITE, `AREA_CORE_IO, 16'h0007, 16'h0001, 1'b1);
		@(posedge mclk);
		loc <= 1'b1;
		chk("refreshes", hits, n);
		$display("remote test done");
	endtask
	task automatic t_bad();
		for (int a = 4; a < 7; a++) begin
			issue(`OP_WRITE, a[2:0], 16'h0005, 16'h0003, 1'b0);
			chk("area error", oerr, 1'b1);
		end
		issue(`OP_WRITE, `AREA_WORK, 16'h0200, 16'h0000, 1'b0);
		chk("work over", oerr, 1'b1);
		issue(`OP_WRITE, `AREA_WORK, 16'h01FF, 16'h0000, 1'b0);
		chk("work last", oerr, 1'b0);
		$display("operand test done");
	endtask
	task automatic t_latch();
		latch(1'b1, 1'b0, 1'b1);
		latch(1'b0, 1'b0, 1'b1);
		latch(1'b0, 1'b1, 1'b0);
		latch(1'b1, 1'b1, 1'b0);
		latch(1'b1, 1'b0, 1'b1);
		@(posedge mclk);
		ilk <= 1'b1;
		repeat (3) @(posedge mclk);
		latch(1'b0, 1'b1, 1'b1);
		@(posedge mclk);
		ilk <= 1'b0;
		repeat (3) @(posedge mclk);
		$display("latch test done");
	endtask
	task automatic power_cycle(input logic keep, input logic opt);
		@(posedge mclk);
		retain <= keep;
		hold_opt <= opt;
		rst_n <= 1'b0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (24) @(posedge mclk);
	endtask
	task automatic t_power();
		cond_set(1'b1);
		issue(`OP_WRITE, `AREA_HOLD, 16'h0002, 16'h0001, 1'b0);
		power_cycle(1'b1, 1'b0);
		chk("retain off", act, 1'b0);
		issue(`OP_TSTN_LD, `AREA_CORE_IO, 16'h0005, 16'h0003, 1'b0);
		chk("io scrubbed", cond, 1'b1);
		issue(`OP_TSTN_LD, `AREA_HOLD, 16'h0002, 16'h0001, 1'b0);
		chk("hold kept", cond, 1'b0);
		cond_set(1'b1);
		issue(`OP_WRITE, `AREA_CORE_IO, 16'h0005, 16'h0003, 1'b0);
		power_cycle(1'b1, 1'b1);
		chk("retain on", act, 1'b1);
		issue(`OP_TSTN_LD, `AREA_CORE_IO, 16'h0005, 16'h0003, 1'b0);
		chk("io kept", cond, 1'b0);
		$display("power test done");
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (24) @(posedge mclk);
		t_write();
		t_test();
		t_remote();
		t_bad();
		t_latch();
		t_power();
		finish_test();
	end
	initial begin
		#20000;
		mismatches++;
		finish_test();
	end
endmodule
`default_nettype wire
